// ---- pkg/cmr_defines.vh ----
// Constants of the clock manager control and reconfiguration port
// How it works
// - All control and status active high
// - Select high picks primary, low secondary
// - Reset stops asynchronously, restarts synchronously
// - Locks by itself after power on
// - Lock drops on stopped clock, misalignment
// - Separate reference and feedback stopped flags
// - Power down shuts the manager off
// - Seven-bit address picks one 16-bit word
// - Writes go through shadow, commit later
// - Done means port takes next write
// - Write enable high writes, low reads
// - Nothing happens without the access strobe
// - Strobe outside power down with no access open answered by done, data
// - Accept divide change request input
// - Acknowledge once divide change is complete
// - Read returns addressed configuration word
// - Port timed on reconfiguration clock rising
`ifndef CMR_DEFINES_VH
`define CMR_DEFINES_VH

// System clock period
`define CMR_CLK_NS       5
// Clock stop detection time and derived cycles (rounded down)
`define CMR_STOP_NS      100
`define CMR_STOP_CYC     (`CMR_STOP_NS / `CMR_CLK_NS)
// Shadow to cell commit time and derived cycles (rounded up)
`define CMR_COMMIT_NS    40
`define CMR_COMMIT_CYC   ((`CMR_COMMIT_NS + `CMR_CLK_NS - 1) / `CMR_CLK_NS)
// Reference edges needed before lock is declared
`define CMR_LOCK_EDGES   8'h40

// Configuration word addresses
`define CMR_ADDR_OUT_DIV 7'h08
`define CMR_ADDR_FB_DIV  7'h14
// Divider field in a configuration word
`define CMR_DIV_MSB      6
`define CMR_DIV_LSB      0
// Reset value of each configuration word
`define CMR_CFG_RST      16'h0000

// Synchroniser bundle field positions
`define CMR_S_WDATA_LSB  0
`define CMR_S_ADDR_LSB   16
`define CMR_S_WE         23
`define CMR_S_STB        24
`define CMR_S_REQ        25
`define CMR_S_RCLK       26
`define CMR_S_FB         27
`define CMR_S_PWR        28
`define CMR_S_SEL        29
`define CMR_S_SEC        30
`define CMR_S_PRI        31
`define CMR_S_WIDTH      32

`endif

// ---- testbench/cmr_chk.sv ----
// Port assertions for the clock manager top level
`timescale 1ns/10ps
module cmr_chk (
  // System clock and reset
  input wire        ref_clk,
  input wire        srst,
  // Control and status
  input wire        mgr_rst,
  input wire        power_down_in,
  input wire        locked,
  input wire        clk_out_en,
  input wire        ref_clk_stopped_flag,
  input wire        divide_change_req,
  input wire        divide_change_ack,
  // Reconfiguration port
  input wire        reconfig_clk,
  input wire        reconfig_strobe,
  input wire        reconfig_write_en,
  input wire [15:0] reconfig_rdata,
  input wire        reconfig_done
);
  default disable iff (srst);

  // Manager status, system clock domain; pin levels reach the logic four cycles late
  property p_rst_stop; @(posedge ref_clk) mgr_rst |=> !locked; endproperty
  a_rst_stop: assert property (p_rst_stop) else $error("lock high in reset");
  property p_pwr; @(posedge ref_clk) power_down_in [*7] |-> !locked && !clk_out_en; endproperty
  a_pwr: assert property (p_pwr) else $error("active in power down");
  property p_drop; @(posedge ref_clk) $rose(ref_clk_stopped_flag) |-> ##[0:3] !locked; endproperty
  a_drop: assert property (p_drop) else $error("lock kept on stop");
  property p_ack_clr; @(posedge ref_clk) $rose(divide_change_req) |-> ##6 !divide_change_ack; endproperty
  a_ack_clr: assert property (p_ack_clr) else $error("ack kept on request");
  property p_ack_cause; @(posedge ref_clk) $rose(divide_change_ack) |-> !divide_change_req; endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack during request");
  property p_pause; @(posedge ref_clk) divide_change_req [*6] |-> !clk_out_en; endproperty
  a_pause: assert property (p_pause) else $error("enable during request");

  // Port handshake, sampled where the user samples it
  property p_done_pulse; @(posedge reconfig_clk) reconfig_done |=> !reconfig_done; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done too long");
  property p_rd;
    @(posedge reconfig_clk) reconfig_strobe && !reconfig_write_en && !power_down_in |=> ##1 reconfig_done;
  endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  // Commit is just shorter than one port cycle, so done follows a write at the read's edge or one port cycle later
  property p_wr;
    @(posedge reconfig_clk) reconfig_strobe && reconfig_write_en && !power_down_in
      |=> !reconfig_done ##[1:2] reconfig_done;
  endproperty
  a_wr: assert property (p_wr) else $error("write done timing");
  property p_cause;
    @(posedge reconfig_clk) $rose(reconfig_done)
      |-> $past(reconfig_strobe) || $past(reconfig_strobe, 2) || $past(reconfig_strobe, 3);
  endproperty
  a_cause: assert property (p_cause) else $error("done without strobe");
  property p_rdata;
    @(posedge reconfig_clk) !(reconfig_strobe && !reconfig_write_en) |=> $stable(reconfig_rdata);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data moved");

  // Main scenarios reached
  c_read: cover property (@(posedge reconfig_clk) reconfig_strobe && !reconfig_write_en);
  c_ack: cover property (@(posedge ref_clk) $rose(divide_change_ack));
  c_drop: cover property (@(posedge ref_clk) $fell(locked));
endmodule

// ---- testbench/cmr_user.sv ----
// User-side model: reference clocks, port clock and port master
`timescale 1ns/10ps
module cmr_user (
  // Stop controls from the bench
  input  wire         pri_stop,
  input  wire         fb_cut,
  // Clocks to the manager
  output logic        primary_ref_clk,
  output logic        secondary_ref_clk,
  output logic        reconfig_clk,
  // Feedback loop
  input  wire         feedback_clk_out,
  output wire         feedback_clk_in,
  // Port master
  output logic [6:0]  reconfig_addr,
  output logic [15:0] reconfig_wdata,
  output logic        reconfig_write_en,
  output logic        reconfig_strobe,
  input  wire  [15:0] reconfig_rdata,
  input  wire         reconfig_done
);
  // Idle port held at zero
  initial begin
    primary_ref_clk   = 1'b0;
    secondary_ref_clk = 1'b0;
    reconfig_clk      = 1'b0;
    reconfig_addr     = 7'h00;
    reconfig_wdata    = 16'h0000;
    reconfig_write_en = 1'b0;
    reconfig_strobe   = 1'b0;
  end

  // Odd periods keep all clocks unrelated to ref_clk; a dead clock parks low
  always #20.7 primary_ref_clk = ~primary_ref_clk & ~pri_stop;
  always #31.1 secondary_ref_clk = ~secondary_ref_clk;
  always #21.3 reconfig_clk = ~reconfig_clk;
  assign feedback_clk_in = feedback_clk_out & ~fb_cut;

  // One access; inputs move on the falling edge since the manager samples
  // them through a synchroniser and needs them steady around the rising edge
  task automatic access(input logic we, input logic [6:0] addr, input logic [15:0] wdata,
                        output logic [15:0] rdata, output logic ok);
    int n;
    @(negedge reconfig_clk);
    reconfig_strobe   <= 1'b1;
    reconfig_write_en <= we;
    reconfig_addr     <= addr;
    reconfig_wdata    <= wdata;
    @(negedge reconfig_clk);
    reconfig_strobe   <= 1'b0;
    reconfig_write_en <= 1'b0;
    reconfig_addr     <= 7'h00;
    reconfig_wdata    <= 16'h0000;
    ok = 1'b0;
    // No new access until done is seen at a rising edge
    for (n = 0; n < 8 && !ok; n++) begin
      @(posedge reconfig_clk);
      ok = (reconfig_done === 1'b1);
    end
    rdata = reconfig_rdata;
  endtask
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the clock manager port block
`include "cmr_defines.vh"
`timescale 1ns/10ps
module testbench;
  // Bench-driven controls
  logic        ref_clk;
  logic        srst;
  logic        ref_clk_select;
  logic        mgr_rst;
  logic        power_down_in;
  logic        divide_change_req;
  logic        pri_stop;
  logic        fb_cut;
  // Manager and partner wires
  wire         primary_ref_clk, secondary_ref_clk, reconfig_clk;
  wire         feedback_clk_in, feedback_clk_out, feedback_clk_out_inv, clk_out_en;
  wire         locked, ref_clk_stopped_flag, fb_clk_stopped_flag, divide_change_ack;
  wire [6:0]   reconfig_addr;
  wire [15:0]  reconfig_wdata, reconfig_rdata;
  wire         reconfig_write_en, reconfig_strobe, reconfig_done;
  // Model and bookkeeping
  logic [15:0] mem [128];
  logic [6:0]  a;
  logic [15:0] d;
  int          i, n, errors, checks_done;

  cmr_top DUT (
    .ref_clk, .srst, .primary_ref_clk, .secondary_ref_clk, .feedback_clk_in,
    .ref_clk_select, .mgr_rst, .power_down_in, .feedback_clk_out, .feedback_clk_out_inv,
    .clk_out_en, .locked, .ref_clk_stopped_flag, .fb_clk_stopped_flag, .reconfig_clk,
    .reconfig_addr, .reconfig_wdata, .reconfig_write_en, .reconfig_strobe,
    .reconfig_rdata, .reconfig_done, .divide_change_req, .divide_change_ack
  );

  cmr_user u_user (
    .pri_stop, .fb_cut, .primary_ref_clk, .secondary_ref_clk, .reconfig_clk,
    .feedback_clk_out, .feedback_clk_in, .reconfig_addr, .reconfig_wdata,
    .reconfig_write_en, .reconfig_strobe, .reconfig_rdata, .reconfig_done
  );

  // 200 MHz system clock
  always #2.5 ref_clk = ~ref_clk;

  task automatic fail(input string m);
    errors++;
    $display("unexpected at %0t: %s", $time, m);
  endtask

  task automatic chk(input bit ok, input string m);
    checks_done++;
    if (!ok)
      fail(m);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Bounded wait on one status output
  task automatic wait_until(input int s);
    int k;
    bit hit;
    hit = 1'b0;
    for (k = 0; k < 4000 && !hit; k++) begin
      @(negedge ref_clk);
      case (s)
        0: hit = locked === 1'b1;
        1: hit = ref_clk_stopped_flag === 1'b1;
        2: hit = fb_clk_stopped_flag === 1'b1;
        3: hit = divide_change_ack === 1'b1;
        default: hit = clk_out_en === 1'b1;
      endcase
    end
    if (!hit) begin
      fail("wait ran out");
      complete_run;
    end
  endtask

  // Port access checked against the model
  task automatic rw(input logic we, input logic [6:0] adr, input logic [15:0] dat);
    logic [15:0] q;
    logic ok;
    u_user.access(we, adr, dat, q, ok);
    if (ok !== 1'b1) begin
      fail("no done");
      complete_run;
    end
    if (we)
      mem[adr] = dat;
    else
      chk(q === mem[adr], "read data");
  endtask

  // Reset the manager, switch reference while held, wait for lock
  task automatic recover(input logic sel);
    @(posedge ref_clk);
    mgr_rst <= 1'b1;
    repeat (2) @(negedge ref_clk);
    chk(locked === 1'b0, "lock in reset");
    @(posedge ref_clk);
    ref_clk_select <= sel;
    repeat (4) @(posedge ref_clk);
    mgr_rst <= 1'b0;
    wait_until(0);
    repeat (2) @(negedge ref_clk);
  endtask

  initial begin
    ref_clk = 1'b0;
    srst = 1'b1;
    ref_clk_select = 1'b1;
    mgr_rst = 1'b0;
    power_down_in = 1'b0;
    divide_change_req = 1'b0;
    pri_stop = 1'b0;
    fb_cut = 1'b0;
    errors = 0;
    checks_done = 0;
    foreach (mem[k]) mem[k] = `CMR_CFG_RST;
    void'($urandom(32'h0000_56e0));
    repeat (19) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(locked === 1'b0 && reconfig_done === 1'b0 && feedback_clk_out_inv === 1'b1 &&
        reconfig_rdata === 16'h0000 && divide_change_ack === 1'b0, "reset values");
    @(posedge ref_clk);
    srst <= 1'b0;
    wait_until(0);
    $display("test lock done");
    // Top of the map, then random write and read-back pairs
    rw(1'b0, 7'h7f, 16'h0000);
    for (i = 0; i < 16; i++) begin
      a = (i == 0) ? 7'h7f : 7'($urandom);
      // A slow feedback divider would stop the loop, so that word keeps its reset value
      if (a == `CMR_ADDR_FB_DIV)
        a = a + 7'h01;
      d = 16'($urandom);
      rw(1'b1, a, d);
      rw(1'b0, a, d);
      rw(1'b0, 7'($urandom), d);
    end
    $display("test port done");
    // Divide change: new divider of 3 gives an enable every 4 cycles
    @(posedge ref_clk);
    divide_change_req <= 1'b1;
    rw(1'b1, `CMR_ADDR_OUT_DIV, 16'h0003);
    @(posedge ref_clk);
    divide_change_req <= 1'b0;
    wait_until(3);
    wait_until(4);
    for (n = 1; n < 300; n++) begin
      @(negedge ref_clk);
      if (clk_out_en === 1'b1)
        break;
    end
    chk(n == 4, "output divide");
    $display("test divide done");
    // Primary dies; relock on the secondary
    @(posedge ref_clk);
    pri_stop <= 1'b1;
    wait_until(1);
    repeat (4) @(negedge ref_clk);
    chk(locked === 1'b0, "lock after stop");
    recover(1'b0);
    chk(ref_clk_stopped_flag === 1'b0, "ref flag clear");
    $display("test switch done");
    // Feedback loop cut
    @(posedge ref_clk);
    fb_cut <= 1'b1;
    wait_until(2);
    @(posedge ref_clk);
    fb_cut <= 1'b0;
    recover(1'b0);
    chk(fb_clk_stopped_flag === 1'b0, "fb flag clear");
    $display("test feedback done");
    // Power down
    @(posedge ref_clk);
    power_down_in <= 1'b1;
    repeat (10) @(negedge ref_clk);
    chk(locked === 1'b0 && clk_out_en === 1'b0 && feedback_clk_out === 1'b0 &&
        feedback_clk_out_inv === 1'b1, "power down");
    @(posedge ref_clk);
    power_down_in <= 1'b0;
    recover(1'b0);
    $display("test power done");
    complete_run;
  end
endmodule

bind cmr_top cmr_chk u_chk (
  .ref_clk, .srst, .mgr_rst, .power_down_in, .locked, .clk_out_en, .ref_clk_stopped_flag,
  .divide_change_req, .divide_change_ack, .reconfig_clk, .reconfig_strobe,
  .reconfig_write_en, .reconfig_rdata, .reconfig_done
);

// ---- verilog/cmr_clk_mon.v ----
// Clock activity monitor: edge pulse and stopped detection
`include "cmr_defines.vh"
`timescale 1ns/10ps
module cmr_clk_mon (
  // Clock and reset
  input  wire ref_clk,
  input  wire srst,
  // Monitored clock level, already synchronised
  input  wire mon_lvl,
  input  wire mon_en,
  // Results
  output reg  rise_q,
  output reg  stopped_q
);

  reg       lvl_q;
  reg [7:0] idle_q;

  // Counts system cycles since the last rising edge; disabled means idle
  always @(posedge ref_clk) begin
    if (srst || !mon_en) begin
      lvl_q     <= 1'b0;
      rise_q    <= 1'b0;
      idle_q    <= 8'h00;
      stopped_q <= 1'b0;
    end else begin
      lvl_q  <= mon_lvl;
      rise_q <= mon_lvl & ~lvl_q;
      if (mon_lvl & ~lvl_q) begin
        idle_q    <= 8'h00;
        stopped_q <= 1'b0;
      end else if (idle_q == `CMR_STOP_CYC) begin
        stopped_q <= 1'b1;
      end else begin
        idle_q <= idle_q + 8'h01;
      end
    end
  end

endmodule

// ---- verilog/cmr_sync.v ----
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module cmr_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input  wire             ref_clk,
  input  wire             srst,
  // Asynchronous input and filtered result
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_q
);

  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;
  integer         i;

  // Stage one is read only by stage two; a bit moves once stages two and three agree
  always @(posedge ref_clk) begin
    if (srst) begin
      s1_q   <= {WIDTH{1'b0}};
      s2_q   <= {WIDTH{1'b0}};
      s3_q   <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (s2_q[i] == s3_q[i]) begin
          sync_q[i] <= s3_q[i];
        end
      end
    end
  end

endmodule

// ---- verilog/cmr_top.v ----
// Clock manager control, status and reconfiguration port
`include "cmr_defines.vh"
`timescale 1ns/10ps
module cmr_top (
  // System clock and reset
  input  wire        ref_clk,
  input  wire        srst,
  // Reference and feedback clock pins
  input  wire        primary_ref_clk,
  input  wire        secondary_ref_clk,
  input  wire        feedback_clk_in,
  // Control inputs
  input  wire        ref_clk_select,
  input  wire        mgr_rst,
  input  wire        power_down_in,
  // Clock outputs
  output reg         feedback_clk_out,
  output reg         feedback_clk_out_inv,
  output reg         clk_out_en,
  // Status outputs
  output reg         locked,
  output reg         ref_clk_stopped_flag,
  output reg         fb_clk_stopped_flag,
  // Reconfiguration port
  input  wire        reconfig_clk,
  input  wire [6:0]  reconfig_addr,
  input  wire [15:0] reconfig_wdata,
  input  wire        reconfig_write_en,
  input  wire        reconfig_strobe,
  output reg  [15:0] reconfig_rdata,
  output reg         reconfig_done,
  // Divide change handshake
  input  wire        divide_change_req,
  output reg         divide_change_ack
);

  // Everything runs on ref_clk. The reference, feedback and port clock pins are only
  // levels here: each passes the three-stage filter with the port inputs beside it, so
  // a port clock edge and the inputs that it qualifies arrive on the same system edge.
  // The price is latency: the port sees an access some four system cycles after the
  // port clock rises, and its outputs move that long after the edge. The port clock
  // must therefore be much slower than ref_clk, and its inputs must stand a few system
  // cycles past the edge that takes them.
  // Any level on a clock pin must stand for two system cycles or the filter hides it,
  // which is why the feedback output never toggles faster than every second cycle.

  // Commit countdown load, cut to the counter width on purpose
  localparam [31:0] CMR_COMMIT_LOAD = `CMR_COMMIT_CYC - 1;

  // Synchronised pin bundle
  wire [`CMR_S_WIDTH-1:0] pins_s;
  wire [6:0]              addr_s;
  wire [15:0]             wdata_s;
  wire                    we_s;
  wire                    stb_s;
  wire                    req_s;
  wire                    rclk_s;
  wire                    fb_s;
  wire                    pwr_s;
  wire                    sel_s;
  wire                    ref_sel_lvl;

  // Monitor outputs
  wire                    ref_rise;
  wire                    ref_stop;
  wire                    fb_rise;
  wire                    fb_stop;

  // Reset hold chain, run state and lock
  reg  [2:0]              hold_q;
  wire                    stopped_rst;
  wire                    active;
  reg                     sel_q;
  reg  [7:0]              lock_cnt_q;
  reg                     fb_seen_q;

  // Reconfiguration state
  reg  [15:0]             cfg_mem [0:127];
  reg                     rclk_q;
  wire                    rck_rise;
  reg  [6:0]              sh_addr_q;
  reg  [15:0]             sh_data_q;
  reg  [3:0]              commit_q;
  reg                     commit_busy_q;
  reg                     pend_q;
  reg                     chg_wr_q;
  reg                     req_q;

  // Divider state
  reg  [6:0]              out_cnt_q;
  reg  [6:0]              fb_cnt_q;
  wire [6:0]              out_div;
  wire [6:0]              fb_div;
  integer                 i;

  // Every pin from the outside but ref_clk, srst and mgr_rst passes the three-stage filter
  cmr_sync #(
    .WIDTH (`CMR_S_WIDTH)
  ) u_sync (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .async_in ({primary_ref_clk, secondary_ref_clk, ref_clk_select, power_down_in,
                feedback_clk_in, reconfig_clk, divide_change_req, reconfig_strobe,
                reconfig_write_en, reconfig_addr, reconfig_wdata}),
    .sync_q   (pins_s)
  );

  // Bundle fields
  assign wdata_s = pins_s[`CMR_S_WDATA_LSB +: 16];
  assign addr_s  = pins_s[`CMR_S_ADDR_LSB +: 7];
  assign we_s    = pins_s[`CMR_S_WE];
  assign stb_s   = pins_s[`CMR_S_STB];
  assign req_s   = pins_s[`CMR_S_REQ];
  assign rclk_s  = pins_s[`CMR_S_RCLK];
  assign fb_s    = pins_s[`CMR_S_FB];
  assign pwr_s   = pins_s[`CMR_S_PWR];
  assign sel_s   = pins_s[`CMR_S_SEL];

  // Reference multiplexer: high picks primary, low picks secondary
  // The select passes the filter too, so a switch lands some cycles after the pin moves
  assign ref_sel_lvl = sel_s ? pins_s[`CMR_S_PRI] : pins_s[`CMR_S_SEC];

  // Manager reset: stops at once, release travels three edges before restart.
  // Only constants are loaded under the asynchronous branch.
  // The release walks the chain, so a restart is clean even when it lands near an edge.
  always @(posedge ref_clk or posedge mgr_rst) begin
    if (mgr_rst) begin
      hold_q <= 3'b111;
    end else if (srst) begin
      hold_q <= 3'b111;
    end else begin
      hold_q <= {hold_q[1:0], 1'b0};
    end
  end

  assign stopped_rst = hold_q[2];
  // Power down and reset both leave the manager idle
  assign active      = ~stopped_rst & ~pwr_s;

  // Reference clock activity
  cmr_clk_mon u_ref_mon (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .mon_lvl   (ref_sel_lvl),
    .mon_en    (active),
    .rise_q    (ref_rise),
    .stopped_q (ref_stop)
  );

  // Feedback clock activity
  cmr_clk_mon u_fb_mon (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .mon_lvl   (fb_s),
    .mon_en    (active),
    .rise_q    (fb_rise),
    .stopped_q (fb_stop)
  );

  // Lock acquisition: counts reference edges with feedback alive; no extra reset needed.
  // A select change while running breaks phase alignment, so lock falls too.
  always @(posedge ref_clk) begin
    if (srst) begin
      sel_q      <= 1'b0;
      fb_seen_q  <= 1'b0;
      lock_cnt_q <= 8'h00;
      locked     <= 1'b0;
    end else begin
      sel_q <= sel_s;
      // Remember a feedback edge so a reference edge need not coincide with one
      if (fb_rise) begin
        fb_seen_q <= 1'b1;
      end
      if (!active || ref_stop || fb_stop || (sel_q != sel_s)) begin
        fb_seen_q  <= 1'b0;
        lock_cnt_q <= 8'h00;
        locked     <= 1'b0;
      end else if (lock_cnt_q == `CMR_LOCK_EDGES) begin
        locked <= 1'b1;
      end else if (ref_rise && fb_seen_ok(fb_rise, fb_seen_q)) begin
        lock_cnt_q <= lock_cnt_q + 8'h01;
      end
    end
  end

  // A reference edge counts only once feedback has been seen alive in this run
  function fb_seen_ok;
    input rise;
    input seen;
    begin
      fb_seen_ok = rise | seen;
    end
  endfunction

  // Stopped flags: set by the monitor, cleared only once lock returns.
  // Set wins over clear in the same cycle.
  // A flag left standing after relock would hide the next stop, so lock clears it.
  always @(posedge ref_clk) begin
    if (srst) begin
      ref_clk_stopped_flag <= 1'b0;
      fb_clk_stopped_flag  <= 1'b0;
    end else begin
      if (ref_stop) begin
        ref_clk_stopped_flag <= 1'b1;
      end else if (locked) begin
        ref_clk_stopped_flag <= 1'b0;
      end
      if (fb_stop) begin
        fb_clk_stopped_flag <= 1'b1;
      end else if (locked) begin
        fb_clk_stopped_flag <= 1'b0;
      end
    end
  end

  // Reconfiguration clock edge, seen after the filter
  // Only the filtered level is compared, so each port period yields one edge pulse
  always @(posedge ref_clk) begin
    if (srst) begin
      rclk_q <= 1'b0;
    end else begin
      rclk_q <= rclk_s;
    end
  end

  assign rck_rise = rclk_s & ~rclk_q;

  // Reconfiguration port. An access is taken at a reconfiguration clock edge with the
  // strobe high; done follows at the next edge, for a write the first edge after its commit, and stands for exactly one period, so the
  // user sees it at one rising edge only. Strobes while an access is open are ignored.
  // A write is answered only once committed, so a read right after it sees the new word.
  always @(posedge ref_clk) begin
    if (srst) begin
      sh_addr_q      <= 7'h00;
      sh_data_q      <= 16'h0000;
      commit_q       <= 4'h0;
      commit_busy_q  <= 1'b0;
      pend_q         <= 1'b0;
      reconfig_done  <= 1'b0;
      reconfig_rdata <= 16'h0000;
      for (i = 0; i < 128; i = i + 1) begin
        cfg_mem[i] <= `CMR_CFG_RST;
      end
    end else begin
      // Shadow to cell commit runs on the system clock
      if (commit_busy_q) begin
        if (commit_q == 4'h0) begin
          cfg_mem[sh_addr_q] <= sh_data_q;
          commit_busy_q      <= 1'b0;
        end else begin
          commit_q <= commit_q - 4'h1;
        end
      end
      if (rck_rise) begin
        // Done lasts one reconfiguration period
        reconfig_done <= pend_q & ~commit_busy_q;
        if (pend_q && !commit_busy_q) begin
          pend_q <= 1'b0;
        end
        if (stb_s && !pend_q && !pwr_s) begin
          pend_q <= 1'b1;
          if (we_s) begin
            // Write lands in the shadow first; cells change later
            sh_addr_q     <= addr_s;
            sh_data_q     <= wdata_s;
            commit_q      <= CMR_COMMIT_LOAD[3:0];
            commit_busy_q <= 1'b1;
          end else begin
            // Read returns the addressed word and holds it to the next read
            reconfig_rdata <= cfg_mem[addr_s];
          end
        end
      end
    end
  end

  // Divide change: writes inside a request are noted; acknowledge rises once the request
  // falls with every such write committed, and stays until a new request starts.
  // Waiting for the last commit means the new divider is in force when ack rises.
  always @(posedge ref_clk) begin
    if (srst) begin
      req_q             <= 1'b0;
      chg_wr_q          <= 1'b0;
      divide_change_ack <= 1'b0;
    end else begin
      req_q <= req_s;
      if (req_s && !req_q) begin
        divide_change_ack <= 1'b0;
        chg_wr_q          <= 1'b0;
      end else if (req_s && commit_busy_q) begin
        chg_wr_q <= 1'b1;
      end else if (!req_s && chg_wr_q && !commit_busy_q && !pend_q) begin
        divide_change_ack <= 1'b1;
        chg_wr_q          <= 1'b0;
      end
    end
  end

  // Divider values come from the committed configuration words
  assign out_div = cfg_mem[`CMR_ADDR_OUT_DIV][`CMR_DIV_MSB:`CMR_DIV_LSB];
  assign fb_div  = cfg_mem[`CMR_ADDR_FB_DIV][`CMR_DIV_MSB:`CMR_DIV_LSB];

  // Output clock enable: one pulse every out_div+1 cycles while locked. Held off during
  // a divide change so no runt period leaks out while counters are being rewritten.
  always @(posedge ref_clk) begin
    if (srst) begin
      out_cnt_q  <= 7'h00;
      clk_out_en <= 1'b0;
    end else if (!locked || req_s) begin
      out_cnt_q  <= 7'h00;
      clk_out_en <= 1'b0;
    end else if (out_cnt_q >= out_div) begin
      out_cnt_q  <= 7'h00;
      clk_out_en <= 1'b1;
    end else begin
      out_cnt_q  <= out_cnt_q + 7'h01;
      clk_out_en <= 1'b0;
    end
  end

  // Feedback output toggles every fb_div+1 cycles while the manager runs and its reference is not stopped, but never
  // faster than every second cycle: a one-cycle level would not pass the pin filter
  // on the way back in, so a zero divider acts as a divider of one.
  always @(posedge ref_clk) begin
    if (srst) begin
      fb_cnt_q             <= 7'h00;
      feedback_clk_out     <= 1'b0;
      feedback_clk_out_inv <= 1'b1;
    end else if (!active || ref_stop) begin
      fb_cnt_q             <= 7'h00;
      feedback_clk_out     <= 1'b0;
      feedback_clk_out_inv <= 1'b1;
    end else if ((fb_cnt_q >= fb_div) && (fb_cnt_q != 7'h00)) begin
      fb_cnt_q             <= 7'h00;
      feedback_clk_out     <= ~feedback_clk_out;
      feedback_clk_out_inv <= feedback_clk_out;
    end else begin
      fb_cnt_q <= fb_cnt_q + 7'h01;
    end
  end

endmodule
